// >>> fsc_pkg.sv
// Constants and carrier types for the fan speed and protection control.
// Assumes a single 125 MHz clock; all counts derive from these figures.
`default_nettype none
package fsc_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 125;
	localparam int RETRY_S = 4;
	localparam longint RETRY_CYC = longint'(RETRY_S) * CLK_MHZ * 1000000;
	localparam int LOCK_MS = 500;
	localparam longint LOCK_CYC = longint'(LOCK_MS) * CLK_MHZ * 1000;
	localparam int SOFT_STEP_US = 100;
	localparam int SOFT_STEP_CYC = SOFT_STEP_US * CLK_MHZ;
	localparam int SWITCH_STEP_CYC = 16;
	// Drive PWM carrier: 8-bit duty, 256 cycles per carrier period
	localparam int DUTY_W = 8;
	localparam int CNT_W = 32;
	localparam int MEAS_W = 16;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
	localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
	localparam logic [DUTY_W-1:0] SOFT_INC = 8'h01;
	localparam logic [DUTY_W-1:0] SWITCH_INC = 8'h10;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		FSC_RUN = 2'b00,
		FSC_SOFT = 2'b01,
		FSC_WAIT = 2'b10,
		FSC_HOT = 2'b11
	} fsc_mode_t;

	typedef struct packed {
		logic a_drive;
		logic a_oe;
		logic b_drive;
		logic b_oe;
	} fsc_bridge_t;

	typedef struct packed {
		logic thermal_shutdown;
		logic overcurrent_trip;
		logic hall_pos_in;
		logic hall_neg_in;
		logic speed_pwm;
	} fsc_pins_t;

	typedef struct packed {
		fsc_pins_t s1;
		fsc_pins_t s2;
		logic hall_last;
		fsc_mode_t mode;
		logic [CNT_W-1:0] timer;
		logic [CNT_W-1:0] lock_timer;
		logic [DUTY_W-1:0] ramp;
		logic [DUTY_W-1:0] sw_gain;
		logic [4:0] sw_timer;
		logic [MEAS_W-1:0] period_cnt;
		logic [MEAS_W-1:0] high_cnt;
		logic [DUTY_W-1:0] cmd_duty;
		logic [DUTY_W-1:0] carrier;
		fsc_bridge_t bridge;
		logic tach_low;
	} fsc_state_t;
endpackage : fsc_pkg
`default_nettype wire

// >>> fsc_fan_ctrl.sv
// Fan speed mapping, commutation, soft switch and protection sequencer.
// Assumes reset_n is driven low by undervoltage lockout logic outside.
// Clock enable low freezes every register, synchronisers included.
`default_nettype none
module fsc_fan_ctrl
	import fsc_pkg::*;
#(
	parameter longint RETRY_CYCLES = RETRY_CYC,
	parameter longint LOCK_CYCLES = LOCK_CYC,
	parameter int SOFT_CYCLES = SOFT_STEP_CYC
) (
	// Clock, reset and enable
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	// Host speed input
	input wire logic speed_pwm,
	// Configuration from the minimum-speed setting
	input wire logic [DUTY_W-1:0] min_duty_threshold,
	input wire logic [DUTY_W-1:0] min_speed_set,
	// Power side sensing
	input wire logic hall_pos_in,
	input wire logic hall_neg_in,
	input wire logic overcurrent_trip,
	input wire logic thermal_shutdown,
	// Motor bridge
	output logic phase_out_a,
	output logic phase_out_a_oe,
	output logic phase_out_b,
	output logic phase_out_b_oe,
	// Tachometer open-drain output
	output logic tach_out,
	output logic tach_out_oe,
	// Status
	output logic drive_active,
	output logic lock_active
);
	// ****************************************************************
	// Terminal counts
	// ****************************************************************
	// Counters compare against count minus one, so a figure of N
	// cycles spans exactly N enabled clocks. Parameters let a bench
	// shorten the seconds-long intervals.
	localparam logic [CNT_W-1:0] RETRY_N = CNT_W'(RETRY_CYCLES - 1);
	localparam logic [CNT_W-1:0] LOCK_N = CNT_W'(LOCK_CYCLES - 1);
	localparam logic [CNT_W-1:0] SOFT_N = CNT_W'(SOFT_CYCLES - 1);
	localparam logic [4:0] SW_N = 5'(SWITCH_STEP_CYC - 1);

	// All state in one packed word; next_st is its copy, built each
	// cycle and registered while the clock enable is high
	fsc_state_t st;
	fsc_state_t next_st;
	fsc_pins_t pins;
	// Derived each cycle from the registered state
	logic hall_now;
	logic hall_edge;
	logic [DUTY_W-1:0] target;
	logic [DUTY_W-1:0] eff_duty;
	logic [DUTY_W-1:0] scaled;
	logic [2*DUTY_W-1:0] prod;
	logic pwm_on;
	logic lock_flag;

	// ****************************************************************
	// Input bundle
	// ****************************************************************
	// Raw pins gathered into one word, so both synchroniser stages
	// copy the same bundle
	assign pins = '{thermal_shutdown: thermal_shutdown,
		overcurrent_trip: overcurrent_trip, hall_pos_in: hall_pos_in,
		hall_neg_in: hall_neg_in, speed_pwm: speed_pwm};

	// ****************************************************************
	// Combinational helpers
	// ****************************************************************
	// Hall comparator result and edge from synchronised inputs
	assign hall_now = st.s2.hall_pos_in & ~st.s2.hall_neg_in;
	// hall_last trails hall_now by one clock, so each change of
	// Hall state gives a one-cycle edge pulse
	assign hall_edge = hall_now ^ st.hall_last;
	// Speed map: full, variable, or floor at minimum setting
	// Variable region never drops below the floor, so the map stays
	// monotonic across the threshold
	always_comb begin
		if (st.cmd_duty == DUTY_FULL) begin
			target = DUTY_FULL;
		end else if (st.cmd_duty > min_duty_threshold) begin
			target = (st.cmd_duty > min_speed_set) ?
				st.cmd_duty : min_speed_set;
		end else begin
			target = min_speed_set;
		end
	end
	// Soft-start ramp limits target, soft switch scales it
	// Ramp caps the target only while soft start runs
	assign eff_duty = (st.mode == FSC_SOFT && st.ramp < target) ?
		st.ramp : target;
	// Soft switch gain scales drive; full gain passes it unchanged
	assign prod = eff_duty * st.sw_gain;
	assign scaled = (st.sw_gain == DUTY_FULL) ? eff_duty :
		prod[2*DUTY_W-1:DUTY_W];
	// Full drive keeps the pair on across the carrier wrap, else the
	// last carrier count would glitch the bridge off
	assign pwm_on = (st.mode == FSC_RUN || st.mode == FSC_SOFT) &&
		(st.carrier < scaled || scaled == DUTY_FULL);
	// Overcurrent waits keep tach released, so only a lock wait
	// shows the flag
	assign lock_flag = st.mode == FSC_WAIT && st.tach_low;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		// Two-flop synchronisers
		// The speed edge detect also reads the first stage, which may
		// still settle from metastability; all else reads the second
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.hall_last = hall_now;
		next_st.carrier = st.carrier + 8'h01;
		// Measure input duty over one full host period, rise to rise.
		// A duty taken at the falling edge would see the high time
		// equal to the elapsed time and always read as full.
		next_st.period_cnt = st.period_cnt + 16'h0001;
		if (st.s2.speed_pwm) begin
			next_st.high_cnt = st.high_cnt + 16'h0001;
		end
		// Rising edge of the synchronised input closes a period
		if (st.s1.speed_pwm && !st.s2.speed_pwm) begin
			if (st.period_cnt == st.high_cnt) begin
				next_st.cmd_duty = DUTY_FULL;
			end else begin
				// High time in 256ths of the period
				next_st.cmd_duty = DUTY_W'(({8'h00, st.high_cnt} << 8) /
					{8'h00, st.period_cnt});
			end
			// This cycle is the first of the new period
			next_st.period_cnt = 16'h0001;
			next_st.high_cnt = 16'h0000;
		end
		// Steady low or high input: 0 or 100 percent.
		// A parked pin never closes a period, so counter overflow
		// doubles as the steady-level detector.
		if (st.period_cnt == 16'hFFFF) begin
			next_st.cmd_duty = st.s2.speed_pwm ? DUTY_FULL : DUTY_ZERO;
			next_st.period_cnt = 16'h0000;
			next_st.high_cnt = 16'h0000;
		end
		// Soft switch: drop drive at each commutation then ramp back
		// Gain climbs in steps instead of jumping, so winding current
		// changes smoothly at every phase switch
		if (hall_edge) begin
			next_st.sw_gain = DUTY_ZERO;
			next_st.sw_timer = 5'h00;
			next_st.tach_low = hall_now;
		end else if (st.sw_gain != DUTY_FULL) begin
			next_st.sw_timer = st.sw_timer + 5'h01;
			if (st.sw_timer == SW_N) begin
				next_st.sw_timer = 5'h00;
				next_st.sw_gain = (st.sw_gain > DUTY_FULL - SWITCH_INC) ?
					DUTY_FULL : st.sw_gain + SWITCH_INC;
			end
		end
		// Lock detect timer restarts on every Hall edge
		// Held at zero while not driving, so a retry gets a full
		// detect window before it can lock again
		if (hall_edge || st.mode == FSC_WAIT || st.mode == FSC_HOT) begin
			next_st.lock_timer = '0;
		end else begin
			next_st.lock_timer = st.lock_timer + 32'h00000001;
		end
		next_st.timer = st.timer + 32'h00000001;
		// Protection sequencer
		// Priority: thermal, then overcurrent, then lock.
		// One timer serves the soft-start steps and the retry wait.
		case (st.mode)
			FSC_RUN, FSC_SOFT: begin
				// Driving: step the ramp, watch for faults
				if (st.mode == FSC_SOFT && st.timer >= SOFT_N) begin
					next_st.timer = '0;
					if (st.ramp >= target) begin
						next_st.mode = FSC_RUN;
					end else begin
						next_st.ramp = st.ramp + SOFT_INC;
					end
				end
				if (st.s2.thermal_shutdown) begin
					next_st.mode = FSC_HOT;
				end else if (st.s2.overcurrent_trip) begin
					next_st.mode = FSC_WAIT;
					next_st.timer = '0;
					next_st.tach_low = 1'b0;
				end else if (st.lock_timer >= LOCK_N) begin
					next_st.mode = FSC_WAIT;
					next_st.timer = '0;
					next_st.tach_low = 1'b1;
				end
			end
			FSC_WAIT: begin
				// Tach holds its entry value: low for a lock, released
				// for overcurrent, so Hall edges cannot fake a lock
				// flag while the motor coasts
				next_st.tach_low = st.tach_low;
				if (st.s2.thermal_shutdown) begin
					next_st.mode = FSC_HOT;
				end else if (st.timer >= RETRY_N) begin
					next_st.mode = FSC_SOFT;
					next_st.timer = '0;
					next_st.ramp = DUTY_ZERO;
					// Tach follows the Hall state again on restart
					next_st.tach_low = hall_now;
				end
			end
			FSC_HOT: begin
				// Drive stays off until the thermal flag clears
				if (!st.s2.thermal_shutdown) begin
					next_st.mode = FSC_SOFT;
					next_st.timer = '0;
					next_st.ramp = DUTY_ZERO;
				end
			end
			default: begin
				// All four encodings are named; an unknown mode falls back to a soft start
				next_st.mode = FSC_SOFT;
			end
		endcase
		// Bridge: on-time drives the pair that the Hall state selects.
		// Off-time floats A and holds B low, so winding current
		// recirculates through the low side.
		// Out of drive every enable drops and the motor coasts.
		next_st.bridge.a_drive = 1'b0;
		next_st.bridge.a_oe = 1'b0;
		next_st.bridge.b_drive = 1'b0;
		next_st.bridge.b_oe = 1'b0;
		if (pwm_on) begin
			// Hall high: B pulled high; Hall low: A pulled high
			next_st.bridge.a_drive = !hall_now;
			next_st.bridge.a_oe = 1'b1;
			next_st.bridge.b_drive = hall_now;
			next_st.bridge.b_oe = 1'b1;
		end else if (st.mode == FSC_RUN || st.mode == FSC_SOFT) begin
			// A released, B sinking
			next_st.bridge.b_oe = 1'b1;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			// Soft start at zero ramp, so drive after undervoltage
			// always ramps up
			st <= '{mode: FSC_SOFT, sw_gain: DUTY_FULL, default: '0};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign phase_out_a = st.bridge.a_drive;
	assign phase_out_a_oe = st.bridge.a_oe;
	assign phase_out_b = st.bridge.b_drive;
	assign phase_out_b_oe = st.bridge.b_oe;
	// Tach is open drain: the pin only ever sinks, never drives high;
	// enable high pulls it low
	assign tach_out = 1'b0;
	assign tach_out_oe = st.tach_low;
	// Status from registered mode, free of input glitches
	// Lock flag stays low during overcurrent waits
	assign drive_active = st.mode == FSC_RUN || st.mode == FSC_SOFT;
	assign lock_active = lock_flag;
endmodule : fsc_fan_ctrl
`default_nettype wire

// >>> fsc_host_pwm.sv
// Host fan controller model: speed PWM, 256-cycle period.
// Assumes the bench holds duty steady between changes.
`default_nettype none
module fsc_host_pwm
	import fsc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Duty request and pin
	input wire logic [DUTY_W-1:0] duty,
	output logic speed_pwm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DUTY_W-1:0] cnt = 8'h00;
	// Period counter
	always @(posedge clock)
		cnt <= reset_n ? cnt + 8'h01 : 8'h00;
	// Full duty stays high all period
	assign speed_pwm = (duty == DUTY_FULL) || (cnt < duty);
endmodule : fsc_host_pwm
`default_nettype wire

// >>> fsc_fan_ctrl_assertions.sv
// Checker on the fan control ports.
// Assumes clk_en high and shortened counts from the bench.
`default_nettype none
module fsc_fan_ctrl_assertions
	import fsc_pkg::*;
#(
	parameter longint RETRY_CYCLES = 2000,
	parameter longint LOCK_CYCLES = 1000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	// Sensing
	input wire logic hall_pos_in,
	input wire logic overcurrent_trip,
	input wire logic thermal_shutdown,
	// Outputs
	input wire logic phase_out_a_oe,
	input wire logic phase_out_b_oe,
	input wire logic tach_out_oe,
	input wire logic drive_active,
	input wire logic lock_active
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || !clk_en);
	logic [31:0] wait_cnt;
	logic [31:0] quiet;
	// Lock wait length and Hall silence
	always_ff @(posedge clock) begin
		wait_cnt <= lock_active ? wait_cnt + 32'h1 : 32'h0;
		quiet <= (!reset_n || $changed(hall_pos_in)) ? 32'h0 : quiet + 32'h1;
	end
	sequence hot_held;
		thermal_shutdown [*4];
	endsequence
	sequence oc_held;
		overcurrent_trip [*4];
	endsequence
	a_reset_state: assert property (disable iff (1'b0)
		!reset_n && clk_en |=> drive_active && !lock_active && !tach_out_oe
		&& !phase_out_a_oe && !phase_out_b_oe) else $error("reset state");
	a_hot_off: assert property (hot_held |-> !drive_active)
		else $error("drive in thermal");
	a_oc_off: assert property (oc_held |-> !drive_active)
		else $error("drive in overcurrent");
	a_lock_outputs: assert property (lock_active [*2] |-> tach_out_oe
		&& !phase_out_a_oe && !phase_out_b_oe) else $error("lock outputs");
	a_lock_detect: assert property ($rose(lock_active)
		|-> quiet >= LOCK_CYCLES) else $error("lock too early");
	a_retry_gap: assert property ($fell(lock_active) |->
		wait_cnt >= RETRY_CYCLES - 2 && wait_cnt <= RETRY_CYCLES + 2)
		else $error("retry gap");
	a_soft_begin: assert property ($rose(drive_active)
		|-> !phase_out_a_oe [*3]) else $error("soft start");
	a_tach_low: assert property ((drive_active && hall_pos_in) [*5]
		|-> tach_out_oe) else $error("tach not low");
endmodule : fsc_fan_ctrl_assertions
`default_nettype wire

// >>> fsc_fan_ctrl_tb.sv
// Bench for the fan control: speed map, protection, tach.
// Assumes the host model and checker are compiled first.
`default_nettype none
module fsc_fan_ctrl_tb
	import fsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Stimulus and scoreboard
	// ****
	logic clock = 1'b0, reset_n = 1'b0, clk_en = 1'b1, hall = 1'b0;
	logic spin = 1'b0, go = 1'b0, speed_pwm;
	logic overcurrent_trip = 1'b0, thermal_shutdown = 1'b0;
	logic [DUTY_W-1:0] duty = 8'h20;
	logic phase_out_a, phase_out_a_oe, phase_out_b, phase_out_b_oe;
	logic tach_out, tach_out_oe, drive_active, lock_active;
	logic [8:0] hall_cnt = 9'h000;
	int num_errors = 0, n_checks = 0, seed = 32'hd25b, exp_q[$];
	fsc_host_pwm u_host (.clock, .reset_n, .duty, .speed_pwm);
	fsc_fan_ctrl #(.RETRY_CYCLES(2000), .LOCK_CYCLES(2000), .SOFT_CYCLES(4))
	u_dut (.clock, .reset_n, .clk_en, .speed_pwm,
		.min_duty_threshold(8'h40), .min_speed_set(8'h30),
		.hall_pos_in(hall), .hall_neg_in(!hall), .overcurrent_trip,
		.thermal_shutdown, .phase_out_a, .phase_out_a_oe, .phase_out_b,
		.phase_out_b_oe, .tach_out, .tach_out_oe, .drive_active, .lock_active);
	always #4 clock = ~clock;
	// Hall pair flips every 300 cycles while the rotor turns
	always @(posedge clock) begin
		hall_cnt <= (spin && hall_cnt != 9'h12B) ? hall_cnt + 9'h001 : 9'h000;
		if (hall_cnt == 9'h12B)
			hall <= ~hall;
	end
	// Count driven-high cycles over one carrier period
	always @(posedge go) begin
		int hi, e;
		hi = 0;
		repeat (256) begin
			@(posedge clock);
			if ((phase_out_a_oe && phase_out_a) === 1'b1
				|| (phase_out_b_oe && phase_out_b) === 1'b1)
				hi++;
		end
		e = exp_q.pop_front();
		n_checks++;
		if (hi < e - 3 || hi > e + 3) begin
			$display("Error drive_count exp %0d seen %0d", e, hi);
			num_errors++;
		end
	end
	task automatic check(input string what, input logic got, input logic e);
		n_checks++;
		if (got !== e) begin
			$display("Error %s exp %b seen %b", what, e, got);
			num_errors++;
		end
	endtask : check
	task automatic wait_lock(input logic lvl, input int lim);
		for (int i = 0; i < lim && lock_active !== lvl; i++)
			@(posedge clock);
		check("lock_active", lock_active, lvl);
		if (lock_active !== lvl)
			give_verdict();
	endtask : wait_lock
	task automatic measure(input logic [7:0] d, input int e, input int wt);
		duty <= d;
		repeat (wt) @(posedge clock);
		spin <= 1'b0;
		repeat (280) @(posedge clock);
		exp_q.push_back(e);
		go <= 1'b1;
		repeat (258) @(posedge clock);
		go <= 1'b0;
		spin <= 1'b1;
	endtask : measure
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		logic [7:0] r;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		spin <= 1'b1;
		measure(8'h20, 48, 1500);
		measure(8'h80, 128, 1500);
		measure(8'hC0, 192, 1500);
		r = 8'h50 + ($random(seed) & 8'h7F);
		measure(r, r, 1500);
		measure(8'hFF, 256, 66000);
		thermal_shutdown <= 1'b1;
		repeat (20) @(posedge clock);
		check("drive_active", drive_active, 1'b0);
		thermal_shutdown <= 1'b0;
		repeat (20) @(posedge clock);
		check("drive_active", drive_active, 1'b1);
		overcurrent_trip <= 1'b1;
		repeat (5) @(posedge clock);
		overcurrent_trip <= 1'b0;
		repeat (1900) @(posedge clock);
		check("drive_active", drive_active, 1'b0);
		repeat (200) @(posedge clock);
		check("drive_active", drive_active, 1'b1);
		spin <= 1'b0;
		wait_lock(1'b1, 2500);
		check("tach_out_oe", tach_out_oe, 1'b1);
		wait_lock(1'b0, 2500);
		wait_lock(1'b1, 3000);
		spin <= 1'b1;
		wait_lock(1'b0, 2500);
		repeat (3000) @(posedge clock);
		check("lock_active", lock_active, 1'b0);
		give_verdict();
	end
endmodule : fsc_fan_ctrl_tb
bind fsc_fan_ctrl fsc_fan_ctrl_assertions #(.RETRY_CYCLES(RETRY_CYCLES),
	.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.clock, .reset_n, .clk_en,
	.hall_pos_in, .overcurrent_trip, .thermal_shutdown, .phase_out_a_oe,
	.phase_out_b_oe, .tach_out_oe, .drive_active, .lock_active);
`default_nettype wire
